// ---- acdm_pkg.sv ----
`default_nettype none
package acdm_pkg;
    localparam int CLOCK_HZ = 250000000;
    localparam int ADDR_W = 5;
    // Register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_PERSIST = 5'h04;
    localparam logic [4:0] OFF_FROZEN_THR = 5'h08;
    localparam logic [4:0] OFF_LEVEL_THR = 5'h0c;
    localparam logic [4:0] OFF_CLKCFG = 5'h10;
    localparam logic [4:0] OFF_FRAME_PERIOD = 5'h14;
    localparam logic [4:0] OFF_STATUS = 5'h18;
    // Control and clock configuration field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_AMP = 1;
    localparam int CTRL_TONE = 2;
    localparam int CTRL_LEVEL = 3;
    localparam int CTRL_FROZEN = 4;
    localparam int CTRL_CLOCK = 5;
    localparam int CTRL_AUTO = 6;
    localparam int CTRL_FMT_LO = 8;
    localparam int CFG_FRMTOL_LO = 4;
    localparam int CFG_RATIO_LO = 8;
    // Audio formats
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_TDM = 2'h2;
    // Frequency window: within 55 % .. 145 % of the expected count
    localparam int FREQ_DEN = 20;
    localparam int FREQ_LO_NUM = 11;
    localparam int FREQ_HI_NUM = 29;

    typedef enum logic [1:0] {CM_IDLE, CM_RUN, CM_FAULT} acdm_cm_e;

    typedef struct packed {
        logic en;
        logic amp;
        logic tone;
        logic lvlEn;
        logic frzEn;
        logic ckEn;
        logic autoRes;
        logic [1:0] fmt;
        logic [15:0] persist;
        logic [23:0] frzThr;
        logic [23:0] lvlThr;
        logic [3:0] freqTol;
        logic [3:0] frmTol;
        logic [9:0] ratio;
        logic [19:0] period;
    } acdm_cfg_s;

    typedef struct packed {
        acdm_cfg_s cfg;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] bSync;
        logic [2:0] fSync;
        logic bLvl;
        logic fLvl;
        logic [23:0] prevSample;
        logic [15:0] frzCnt;
        logic [15:0] lvlCnt;
        logic [19:0] winCnt;
        logic [11:0] bWin;
        logic [20:0] frameAge;
        logic [20:0] lastFrame;
        logic primed;
        logic [10:0] bHi;
        logic [10:0] bLo;
        logic [4:0] freqErrRun;
        logic [4:0] freqOkRun;
        logic [4:0] frmErrRun;
        logic [4:0] frmOkRun;
        acdm_cm_e cmState;
        logic dataIrq;
        logic clkErrIrq;
        logic clkRecIrq;
    } acdm_state_s;

    localparam acdm_state_s ST_RESET = '0;
endpackage
`default_nettype wire

// ---- acdm_monitor.sv ----
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module acdm_monitor #(
    parameter int SAMPLE_W = 24
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [acdm_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [SAMPLE_W-1:0] sampleData,
    input wire logic sampleValid,
    input wire logic bitClkPin,
    input wire logic frameClkPin,
    output logic swShutdown,
    output logic sampleFaultIrq,
    output logic clockFaultIrq,
    output logic clockRecoverIrq
);
    acdm_pkg::acdm_state_s st_ff;
    acdm_pkg::acdm_state_s nxt_st;

    function automatic logic inRange(input logic [31:0] meas, input logic [31:0] expct);
        inRange = (meas * acdm_pkg::FREQ_DEN >= expct * acdm_pkg::FREQ_LO_NUM)
            && (meas * acdm_pkg::FREQ_DEN <= expct * acdm_pkg::FREQ_HI_NUM);
    endfunction

    function automatic logic [SAMPLE_W-1:0] magOf(input logic [SAMPLE_W-1:0] v);
        magOf = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
    endfunction

    function automatic logic [4:0] runStep(input logic [4:0] run, input logic hit);
        runStep = !hit ? 5'h00 : (run == 5'h1f ? run : run + 5'h01);
    endfunction

    logic busReq;
    logic wrTake;
    logic dataActive;
    logic clkActive;
    logic bEdge;
    logic fEdge;
    logic winEnd;
    logic frzHit;
    logic lvlHit;
    logic frmErr;
    logic freqErr;
    logic [4:0] freqNeed;
    logic [4:0] frmNeed;
    logic [SAMPLE_W-1:0] mag;
    logic [31:0] ctrlWord;

    assign busReq = read || write;
    assign waitrequest = busReq && !st_ff.ack;
    assign wrTake = write && st_ff.ack;
    assign readdata = st_ff.rdata;
    // Clock hold also silences the output while the monitor waits to resume
    assign swShutdown = !st_ff.cfg.en || (st_ff.cmState == acdm_pkg::CM_FAULT);
    assign sampleFaultIrq = st_ff.dataIrq;
    assign clockFaultIrq = st_ff.clkErrIrq;
    assign clockRecoverIrq = st_ff.clkRecIrq;
    assign freqNeed = {1'b0, st_ff.cfg.freqTol} + 5'h01;
    assign frmNeed = {1'b0, st_ff.cfg.frmTol} + 5'h01;
    assign mag = magOf(sampleData);

    assign ctrlWord = {22'h0, st_ff.cfg.fmt, 1'b0, st_ff.cfg.autoRes, st_ff.cfg.ckEn,
        st_ff.cfg.frzEn, st_ff.cfg.lvlEn, st_ff.cfg.tone, st_ff.cfg.amp, st_ff.cfg.en};

    // Data path needs the audio path live and the serial input selected
    assign dataActive = (st_ff.cfg.lvlEn || st_ff.cfg.frzEn) && st_ff.cfg.en
        && st_ff.cfg.amp && !st_ff.cfg.tone && (st_ff.cmState != acdm_pkg::CM_FAULT);
    assign clkActive = st_ff.cfg.ckEn && st_ff.cfg.en && !st_ff.cfg.tone;

    // Filtered levels change only once the 2nd and 3rd stages agree
    assign bEdge = (st_ff.bSync[2] == st_ff.bSync[1]) && st_ff.bSync[1] && !st_ff.bLvl;
    assign fEdge = (st_ff.fSync[2] == st_ff.fSync[1]) && st_ff.fSync[1] && !st_ff.fLvl;
    assign winEnd = st_ff.winCnt >= st_ff.cfg.period - 20'h00001;

    assign frzHit = st_ff.cfg.frzEn && (sampleData == st_ff.prevSample)
        && (mag > st_ff.cfg.frzThr[SAMPLE_W-1:0]);
    assign lvlHit = st_ff.cfg.lvlEn && (mag > st_ff.cfg.lvlThr[SAMPLE_W-1:0]);

    assign frmErr = ({1'b0, st_ff.bHi} + {1'b0, st_ff.bLo} != {2'b00, st_ff.cfg.ratio})
        || ((st_ff.cfg.fmt != acdm_pkg::FMT_TDM) && (st_ff.bHi != st_ff.bLo));

    // One window is one programmed frame period; stopped clocks leave counts at zero
    assign freqErr = !inRange(32'(st_ff.bWin), 32'(st_ff.cfg.ratio))
        || (32'(st_ff.frameAge) * acdm_pkg::FREQ_DEN
            > 32'(st_ff.cfg.period) * acdm_pkg::FREQ_HI_NUM)
        || (st_ff.primed && !inRange(32'(st_ff.lastFrame), 32'(st_ff.cfg.period)));

    always_comb begin
        nxt_st = st_ff;
        nxt_st.dataIrq = 1'b0;
        nxt_st.clkErrIrq = 1'b0;
        nxt_st.clkRecIrq = 1'b0;
        nxt_st.bSync = {st_ff.bSync[1:0], bitClkPin};
        nxt_st.fSync = {st_ff.fSync[1:0], frameClkPin};
        if (st_ff.bSync[2] == st_ff.bSync[1]) begin
            nxt_st.bLvl = st_ff.bSync[1];
        end
        if (st_ff.fSync[2] == st_ff.fSync[1]) begin
            nxt_st.fLvl = st_ff.fSync[1];
        end

        // Avalon slave: one wait cycle; read data loads on the edge that raises ack, the write one edge later
        nxt_st.ack = busReq && !st_ff.ack;
        if (read && !st_ff.ack) begin
            case (address)
                acdm_pkg::OFF_CTRL: nxt_st.rdata = ctrlWord;
                acdm_pkg::OFF_PERSIST: nxt_st.rdata = {16'h0, st_ff.cfg.persist};
                acdm_pkg::OFF_FROZEN_THR: nxt_st.rdata = {8'h0, st_ff.cfg.frzThr};
                acdm_pkg::OFF_LEVEL_THR: nxt_st.rdata = {8'h0, st_ff.cfg.lvlThr};
                acdm_pkg::OFF_CLKCFG: nxt_st.rdata = {14'h0, st_ff.cfg.ratio,
                    st_ff.cfg.frmTol, st_ff.cfg.freqTol};
                acdm_pkg::OFF_FRAME_PERIOD: nxt_st.rdata = {12'h0, st_ff.cfg.period};
                acdm_pkg::OFF_STATUS: nxt_st.rdata = {8'h0, st_ff.frmOkRun, st_ff.frmErrRun,
                    st_ff.freqOkRun, st_ff.freqErrRun, 2'h0, st_ff.cmState};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
        if (wrTake) begin
            case (address)
                acdm_pkg::OFF_CTRL: begin
                    nxt_st.cfg.en = writedata[acdm_pkg::CTRL_EN];
                    nxt_st.cfg.amp = writedata[acdm_pkg::CTRL_AMP];
                    nxt_st.cfg.tone = writedata[acdm_pkg::CTRL_TONE];
                    nxt_st.cfg.lvlEn = writedata[acdm_pkg::CTRL_LEVEL];
                    nxt_st.cfg.frzEn = writedata[acdm_pkg::CTRL_FROZEN];
                    nxt_st.cfg.ckEn = writedata[acdm_pkg::CTRL_CLOCK];
                    nxt_st.cfg.autoRes = writedata[acdm_pkg::CTRL_AUTO];
                    nxt_st.cfg.fmt = writedata[acdm_pkg::CTRL_FMT_LO +: 2];
                end
                acdm_pkg::OFF_PERSIST: nxt_st.cfg.persist = writedata[15:0];
                acdm_pkg::OFF_FROZEN_THR: nxt_st.cfg.frzThr = writedata[23:0];
                acdm_pkg::OFF_LEVEL_THR: nxt_st.cfg.lvlThr = writedata[23:0];
                acdm_pkg::OFF_CLKCFG: begin
                    nxt_st.cfg.freqTol = writedata[3:0];
                    nxt_st.cfg.frmTol = writedata[acdm_pkg::CFG_FRMTOL_LO +: 4];
                    nxt_st.cfg.ratio = writedata[acdm_pkg::CFG_RATIO_LO +: 10];
                end
                acdm_pkg::OFF_FRAME_PERIOD: nxt_st.cfg.period = writedata[19:0];
                default: ;
            endcase
        end

        // Data monitor, counted in samples
        if (!dataActive) begin
            nxt_st.frzCnt = 16'h0;
            nxt_st.lvlCnt = 16'h0;
        end else if (sampleValid) begin
            nxt_st.prevSample = sampleData;
            nxt_st.frzCnt = frzHit ? st_ff.frzCnt + 16'h1 : 16'h0;
            nxt_st.lvlCnt = lvlHit ? st_ff.lvlCnt + 16'h1 : 16'h0;
            if ((frzHit && st_ff.frzCnt >= st_ff.cfg.persist)
                || (lvlHit && st_ff.lvlCnt >= st_ff.cfg.persist)) begin
                nxt_st.cfg.en = 1'b0;
                nxt_st.dataIrq = 1'b1;
                nxt_st.frzCnt = 16'h0;
                nxt_st.lvlCnt = 16'h0;
            end
        end

        // Clock monitor; inactive state drops all history silently
        if (!clkActive) begin
            nxt_st.cmState = acdm_pkg::CM_IDLE;
            nxt_st.winCnt = 20'h0;
            nxt_st.bWin = 12'h0;
            nxt_st.frameAge = 21'h0;
            nxt_st.primed = 1'b0;
            nxt_st.bHi = 11'h0;
            nxt_st.bLo = 11'h0;
            nxt_st.freqErrRun = 5'h0;
            nxt_st.freqOkRun = 5'h0;
            nxt_st.frmErrRun = 5'h0;
            nxt_st.frmOkRun = 5'h0;
        end else begin
            if (st_ff.cmState == acdm_pkg::CM_IDLE) begin
                nxt_st.cmState = acdm_pkg::CM_RUN;
            end
            nxt_st.winCnt = winEnd ? 20'h0 : st_ff.winCnt + 20'h1;
            nxt_st.frameAge = (&st_ff.frameAge) ? st_ff.frameAge : st_ff.frameAge + 21'h1;
            if (bEdge) begin
                nxt_st.bWin = (&st_ff.bWin) ? st_ff.bWin : st_ff.bWin + 12'h1;
                if (st_ff.fLvl) begin
                    nxt_st.bHi = st_ff.bHi + 11'h1;
                end else begin
                    nxt_st.bLo = st_ff.bLo + 11'h1;
                end
            end
            if (fEdge) begin
                nxt_st.frameAge = 21'h0;
                // Partial opening frame stands in as nominal, else enable could fault
                nxt_st.lastFrame = st_ff.primed ? st_ff.frameAge : {1'b0, st_ff.cfg.period};
                nxt_st.primed = 1'b1;
                nxt_st.bHi = 11'h0;
                nxt_st.bLo = 11'h0;
                // First edge after activation only opens a frame
                if (st_ff.primed) begin
                    nxt_st.frmErrRun = runStep(st_ff.frmErrRun, frmErr);
                    nxt_st.frmOkRun = runStep(st_ff.frmOkRun, !frmErr);
                end
            end
            if (winEnd) begin
                nxt_st.bWin = 12'h0;
                nxt_st.freqErrRun = runStep(st_ff.freqErrRun, freqErr);
                nxt_st.freqOkRun = runStep(st_ff.freqOkRun, !freqErr);
            end
            case (st_ff.cmState)
                acdm_pkg::CM_RUN: begin
                    if (st_ff.freqErrRun >= freqNeed || st_ff.frmErrRun >= frmNeed) begin
                        nxt_st.clkErrIrq = 1'b1;
                        nxt_st.freqOkRun = 5'h0;
                        nxt_st.frmOkRun = 5'h0;
                        nxt_st.freqErrRun = 5'h0;
                        nxt_st.frmErrRun = 5'h0;
                        if (st_ff.cfg.autoRes) begin
                            nxt_st.cmState = acdm_pkg::CM_FAULT;
                        end else begin
                            nxt_st.cfg.en = 1'b0;
                            nxt_st.cmState = acdm_pkg::CM_IDLE;
                        end
                    end
                end
                acdm_pkg::CM_FAULT: begin
                    if (st_ff.freqOkRun >= freqNeed && st_ff.frmOkRun >= frmNeed) begin
                        nxt_st.clkRecIrq = 1'b1;
                        nxt_st.cmState = acdm_pkg::CM_RUN;
                    end
                end
                default: nxt_st.cmState = acdm_pkg::CM_RUN;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff <= acdm_pkg::ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Pairing tracker read only by the checks below
    logic pendRec_ff;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pendRec_ff <= 1'b0;
        end else if (clockFaultIrq && st_ff.cfg.autoRes) begin
            pendRec_ff <= 1'b1;
        end else if (clockRecoverIrq || !clkActive) begin
            pendRec_ff <= 1'b0;
        end
    end

    AST_DATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
        (!st_ff.cfg.en || !st_ff.cfg.amp) |=> !sampleFaultIrq)
        else $error("data fault raised while monitor idle");
    AST_TONE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.cfg.tone |=> !sampleFaultIrq && !clockFaultIrq)
        else $error("fault raised while tone source active");
    AST_DATA_SHUTDOWN: assert property (@(posedge clock) disable iff (!rst_n)
        sampleFaultIrq |-> !st_ff.cfg.en && swShutdown)
        else $error("data fault without enable cleared");
    AST_CLK_SHUTDOWN: assert property (@(posedge clock) disable iff (!rst_n)
        clockFaultIrq |-> swShutdown)
        else $error("clock fault without shutdown");
    AST_AUTO_KEEPS_EN: assert property (@(posedge clock) disable iff (!rst_n)
        (clockFaultIrq && $past(st_ff.cfg.autoRes)) |-> st_ff.cfg.en)
        else $error("auto mode cleared enable");
    AST_REC_PAIRED: assert property (@(posedge clock) disable iff (!rst_n)
        clockRecoverIrq |-> $past(pendRec_ff))
        else $error("recovery without prior error");
    AST_MANUAL_NO_REC: assert property (@(posedge clock) disable iff (!rst_n)
        (clockFaultIrq && !$past(st_ff.cfg.autoRes)) |-> !st_ff.cfg.en)
        else $error("manual fault left enable set");
    AST_HOST_EXIT_SILENT: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(st_ff.cfg.en) |-> !clockFaultIrq && !clockRecoverIrq ##1 !clockFaultIrq)
        else $error("spurious clock irq at host enable");
    AST_RUN_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        !clkActive |=> st_ff.freqErrRun == 5'h0 && st_ff.frmErrRun == 5'h0)
        else $error("run counters kept while inactive");
    AST_BUS_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
        (busReq && waitrequest) |=> !waitrequest)
        else $error("bus answer late");
    AST_CLK_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        !clkActive |=> !clockFaultIrq && !clockRecoverIrq)
        else $error("clock irq while clock monitor inactive");
    AST_REC_ONLY_FROM_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.cmState != acdm_pkg::CM_FAULT |=> !clockRecoverIrq)
        else $error("recovery irq outside fault hold");
    AST_REC_RESUMES: assert property (@(posedge clock) disable iff (!rst_n)
        clockRecoverIrq |-> st_ff.cmState == acdm_pkg::CM_RUN)
        else $error("recovery without resuming run");
    AST_DATA_AFTER_SAMPLE: assert property (@(posedge clock) disable iff (!rst_n)
        sampleFaultIrq |-> $past(sampleValid))
        else $error("data fault without a sample");
    AST_CLK_IRQ_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        clockFaultIrq |=> !clockFaultIrq)
        else $error("clock fault irq longer than one cycle");
    AST_DATA_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        !dataActive |=> st_ff.frzCnt == 16'h0 && st_ff.lvlCnt == 16'h0)
        else $error("data persistence kept while inactive");
    AST_DATA_INACTIVE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        !dataActive |=> !sampleFaultIrq)
        else $error("data fault while data monitor inactive");
    AST_CLK_FAULT_DUE: assert property (@(posedge clock) disable iff (!rst_n)
        (clkActive && st_ff.cmState == acdm_pkg::CM_RUN
            && (st_ff.freqErrRun >= freqNeed || st_ff.frmErrRun >= frmNeed)) |=> clockFaultIrq)
        else $error("clock fault not raised after error run");
    AST_AUTO_RECOVERS: assert property (@(posedge clock) disable iff (!rst_n)
        (clkActive && st_ff.cmState == acdm_pkg::CM_FAULT && st_ff.freqOkRun >= freqNeed
            && st_ff.frmOkRun >= frmNeed) |=> clockRecoverIrq)
        else $error("recovery not raised after clean run");

    COV_DATA_FAULT: cover property (@(posedge clock) disable iff (!rst_n) sampleFaultIrq);
    COV_CLK_FAULT: cover property (@(posedge clock) disable iff (!rst_n) clockFaultIrq);
    COV_CLK_RECOVER: cover property (@(posedge clock) disable iff (!rst_n) clockRecoverIrq);
    COV_MANUAL_FAULT: cover property (@(posedge clock) disable iff (!rst_n)
        clockFaultIrq && !st_ff.cfg.en);
    COV_TDM_RUN: cover property (@(posedge clock) disable iff (!rst_n)
        clkActive && st_ff.cfg.fmt == acdm_pkg::FMT_TDM);
endmodule // acdm_monitor
`default_nettype wire

// ---- acdm_host_model.sv ----
`default_nettype none
// Far-side audio host: bit clock and frame clock, unrelated in phase to the system clock
module acdm_host_model (
    output logic bitClk,
    output logic frameClk,
    input wire logic run,
    input wire logic [9:0] ratio,
    input wire logic badDuty
);
    timeunit 1ns;
    timeprecision 1ps;
    int half;
    // Stopped clocks rest low between frames
    always begin
        if (!run) begin
            bitClk = 1'b0;
            frameClk = 1'b0;
            #125;
        end else begin
            // Skewed halves only when a duty fault is wanted
            half = badDuty ? int'(ratio) / 2 + 1 : int'(ratio) / 2;
            for (int i = 0; i < int'(ratio); i++) begin
                frameClk = (i >= half);
                #62.5 bitClk = 1'b1;
                #62.5 bitClk = 1'b0;
            end
        end
    end
endmodule // acdm_host_model
`default_nettype wire

// ---- test_audio_clock_data_fault_monitor.sv ----
`default_nettype none
module test_audio_clock_data_fault_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [23:0] sampleData = 24'h0;
    logic sampleValid = 1'b0;
    logic bitClk, frameClk, swShutdown, sampleFaultIrq, clockFaultIrq, clockRecoverIrq;
    logic run = 1'b0;
    logic badDuty = 1'b0;
    logic [31:0] rd;
    int n_fail = 0;
    int checked = 0;
    int evCnt[3] = '{0, 0, 0};

    always #2 clock = ~clock;

    acdm_monitor u_acdm_monitor (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sampleData(sampleData), .sampleValid(sampleValid), .bitClkPin(bitClk),
        .frameClkPin(frameClk), .swShutdown(swShutdown), .sampleFaultIrq(sampleFaultIrq),
        .clockFaultIrq(clockFaultIrq), .clockRecoverIrq(clockRecoverIrq));
    acdm_host_model u_acdm_host_model (.bitClk(bitClk), .frameClk(frameClk), .run(run),
        .ratio(10'h010), .badDuty(badDuty));

    // Pulses are counted so short irqs are never missed between checks
    always @(posedge clock) begin
        if (sampleFaultIrq === 1'b1) evCnt[0]++;
        if (clockFaultIrq === 1'b1) evCnt[1]++;
        if (clockRecoverIrq === 1'b1) evCnt[2]++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Avalon access: request held until waitrequest is sampled low
    task automatic acc(input logic isWr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= isWr;
        read <= ~isWr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk("register read", exp, rd);
    endtask

    task automatic send(input logic [23:0] v, input int n);
        repeat (n) begin
            @(posedge clock);
            sampleData <= v;
            sampleValid <= 1'b1;
        end
        @(posedge clock);
        sampleValid <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic waitEv(input int k, input int target);
        int t;
        t = 0;
        while (evCnt[k] < target && t < 8000) begin
            @(posedge clock);
            t++;
        end
        idle(3);
        chk("irq count", 32'(target), 32'(evCnt[k]));
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rdChk(acdm_pkg::OFF_CTRL, 32'h0);
        chk("shutdown after reset", 32'h1, 32'(swShutdown));
        wr(5'h1c, 32'hffffffff);
        rdChk(5'h1c, 32'h0);
        wr(acdm_pkg::OFF_PERSIST, 32'h2);
        rdChk(acdm_pkg::OFF_PERSIST, 32'h2);
        wr(acdm_pkg::OFF_LEVEL_THR, 32'h100);
        wr(acdm_pkg::OFF_FROZEN_THR, 32'h100);
        // Level check: a broken run must not fault, a full one must
        wr(acdm_pkg::OFF_CTRL, 32'h0b);
        send(24'h000200, 2);
        send(24'h000000, 1);
        chk("no early data irq", 32'h0, 32'(evCnt[0]));
        send(24'hfffe00, 3);
        waitEv(0, 1);
        chk("shutdown after data fault", 32'h1, 32'(swShutdown));
        rdChk(acdm_pkg::OFF_CTRL, 32'h0a);
        wr(acdm_pkg::OFF_CTRL, 32'h09);
        send(24'h000200, 6);
        wr(acdm_pkg::OFF_CTRL, 32'h0f);
        send(24'h000200, 6);
        chk("suspended data monitor", 32'h1, 32'(evCnt[0]));
        // Frozen check: small frozen codes are harmless, large ones fault
        wr(acdm_pkg::OFF_CTRL, 32'h13);
        send(24'h000050, 10);
        chk("small frozen value", 32'h1, 32'(evCnt[0]));
        send(24'h000300, 4);
        waitEv(0, 2);
        // Clock monitor, automatic mode, I2S
        wr(acdm_pkg::OFF_CLKCFG, 32'h1011);
        wr(acdm_pkg::OFF_FRAME_PERIOD, 32'h1f4);
        run <= 1'b1;
        wr(acdm_pkg::OFF_CTRL, 32'h61);
        idle(3000);
        wr(acdm_pkg::OFF_CTRL, 32'h60);
        idle(1000);
        wr(acdm_pkg::OFF_CTRL, 32'h61);
        idle(3000);
        chk("no clock irq on host toggle", 32'h0, 32'(evCnt[1] + evCnt[2]));
        chk("running with good clocks", 32'h0, 32'(swShutdown));
        run <= 1'b0;
        waitEv(1, 1);
        chk("clock fault shutdown", 32'h1, 32'(swShutdown));
        rdChk(acdm_pkg::OFF_CTRL, 32'h61);
        chk("no recovery while stopped", 32'h0, 32'(evCnt[2]));
        run <= 1'b1;
        waitEv(2, 1);
        chk("auto recovery", 32'h0, 32'(swShutdown));
        badDuty <= 1'b1;
        waitEv(1, 2);
        badDuty <= 1'b0;
        waitEv(2, 2);
        // TDM ignores the duty cycle
        wr(acdm_pkg::OFF_CTRL, 32'h261);
        badDuty <= 1'b1;
        idle(4000);
        chk("tdm duty ignored", 32'h2, 32'(evCnt[1]));
        badDuty <= 1'b0;
        // Skewed-duty transition frames must pass before I2S framing is judged again
        idle(1500);
        // Manual mode
        wr(acdm_pkg::OFF_CTRL, 32'h21);
        idle(2000);
        run <= 1'b0;
        waitEv(1, 3);
        rdChk(acdm_pkg::OFF_CTRL, 32'h20);
        run <= 1'b1;
        idle(4000);
        chk("no manual recovery", 32'h2, 32'(evCnt[2]));
        chk("manual stays down", 32'h1, 32'(swShutdown));
        wr(acdm_pkg::OFF_CTRL, 32'h21);
        idle(3000);
        chk("resumed without fault", 32'h3, 32'(evCnt[1]));
        wr(acdm_pkg::OFF_CTRL, 32'h25);
        run <= 1'b0;
        idle(4000);
        chk("tone suspends clock check", 32'h3, 32'(evCnt[1]));
        give_verdict();
    end
endmodule // test_audio_clock_data_fault_monitor
`default_nettype wire
